// ==== design/oag_pkg.sv ====
package oag_pkg;
    localparam int unsigned data_w = 16;
    localparam int unsigned reg_count = 8;
    localparam logic [2:0] pc_reg = 3'h7;
    localparam int unsigned mode_msb = 5;
    localparam int unsigned mode_lsb = 3;
    localparam int unsigned reg_msb = 2;
    localparam int unsigned reg_lsb = 0;
    localparam logic [2:0] mode_register = 3'h0;
    localparam logic [2:0] mode_reg_deferred = 3'h1;
    localparam logic [2:0] mode_autoinc = 3'h2;
    localparam logic [2:0] mode_autoinc_def = 3'h3;
    localparam logic [2:0] mode_autodec = 3'h4;
    localparam logic [2:0] mode_autodec_def = 3'h5;
    localparam logic [2:0] mode_index = 3'h6;
    localparam logic [2:0] mode_index_def = 3'h7;
    localparam logic [5:0] spec_immediate = 6'h17;
    localparam logic [15:0] step_byte = 16'h0001;
    localparam logic [15:0] step_word = 16'h0002;
    localparam logic [15:0] reset_word = 16'h0000;
    typedef enum logic [1:0] {
        res_register,
        res_address,
        res_immediate
    } result_kind_t;
endpackage : oag_pkg

// ==== design/oag_step.sv ====
`timescale 1ns/1ps
// register update amount for a mode
module oag_step (
    input wire logic [2:0] i_mode,
    input wire logic [2:0] i_reg,
    input wire logic i_byte,
    output logic [15:0] o_step
);
    import oag_pkg::*;
    always_comb begin
        // deferred forms and the pc always move a whole word
        if (i_mode[0] || i_reg == pc_reg || !i_byte) begin
            o_step = step_word;
        end else begin
            o_step = step_byte;
        end
    end
endmodule : oag_step

// ==== design/operand_address_generator.sv ====
`timescale 1ns/1ps
module operand_address_generator (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [5:0] i_specifier,
    input wire logic i_byte,
    input wire logic i_wr_en,
    input wire logic [2:0] i_wr_sel,
    input wire logic [15:0] i_wr_data,
    output logic o_bus_req,
    output logic [15:0] o_bus_addr,
    input wire logic i_bus_ack,
    input wire logic [15:0] i_bus_data,
    output logic o_done,
    output logic o_busy,
    output oag_pkg::result_kind_t o_kind,
    output logic [2:0] o_reg_num,
    output logic [15:0] o_value,
    output logic [15:0] o_pc
);
    import oag_pkg::*;

    typedef enum logic [2:0] {
        st_idle,
        st_fetch_index,
        st_fetch_pointer,
        st_finish
    } state_t;

    state_t state_q;
    logic [15:0] gpr_q [reg_count];
    logic [2:0] mode_q;
    logic [2:0] sel_q;
    logic byte_q;
    logic [15:0] addr_q;
    logic [15:0] value_q;
    logic done_q;
    result_kind_t kind_q;
    logic [2:0] mode_d;
    logic [2:0] sel_d;
    logic [15:0] step_w;
    logic [15:0] sel_val;
    logic [15:0] dec_val;
    logic [15:0] ack_step;
    logic [15:0] pc_next;
    logic start_ok;

    // the pc as selected register turns modes 2, 3, 6, 7 into pc forms
    function automatic logic is_pc(input logic [2:0] r);
        return r == pc_reg;
    endfunction : is_pc

    // mode 2 on the pc: the next word is the operand itself
    function automatic logic is_immediate(input logic [2:0] m,
            input logic [2:0] r);
        return m == mode_autoinc && is_pc(r);
    endfunction : is_immediate

    // pointer reads that bump the pointer register afterwards
    function automatic logic pointer_steps(input logic [2:0] m,
            input logic [2:0] r);
        return m == mode_autoinc_def || is_immediate(m, r);
    endfunction : pointer_steps

    // low mode bit adds one level of indirection
    function automatic logic is_deferred(input logic [2:0] m);
        return m[0];
    endfunction : is_deferred

    assign mode_d = i_specifier[mode_msb:mode_lsb];
    assign sel_d = i_specifier[reg_msb:reg_lsb];
    assign sel_val = gpr_q[sel_d];
    // a start while busy is dropped, never queued
    assign start_ok = i_start && state_q == st_idle;

    oag_step u_step (
        .i_mode(mode_d),
        .i_reg(sel_d),
        .i_byte(i_byte),
        .o_step(step_w)
    );

    assign dec_val = sel_val - step_w;
    // pc value once the word it points at has been read
    assign pc_next = gpr_q[pc_reg] + step_word;

    // bump after a pointer read; size decision kept in one module
    oag_step u_ack_step (
        .i_mode(mode_q),
        .i_reg(sel_q),
        .i_byte(byte_q),
        .o_step(ack_step)
    );

    // next state and memory addresses
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_q <= st_idle;
            addr_q <= reset_word;
        end else begin
            unique case (state_q)
                st_idle: begin
                    if (start_ok) begin
                        unique case (mode_d)
                            mode_register, mode_reg_deferred: begin
                                state_q <= st_finish;
                            end
                            mode_autoinc: begin
                                // pc autoinc reads the immediate word
                                if (is_pc(sel_d)) begin
                                    addr_q <= sel_val;
                                    state_q <= st_fetch_pointer;
                                end else begin
                                    state_q <= st_finish;
                                end
                            end
                            mode_autoinc_def: begin
                                addr_q <= sel_val;
                                state_q <= st_fetch_pointer;
                            end
                            mode_autodec: begin
                                state_q <= st_finish;
                            end
                            mode_autodec_def: begin
                                // on the pc too: no bump after this read
                                addr_q <= dec_val;
                                state_q <= st_fetch_pointer;
                            end
                            mode_index, mode_index_def: begin
                                // index word always comes from the pc
                                addr_q <= gpr_q[pc_reg];
                                state_q <= st_fetch_index;
                            end
                        endcase
                    end
                end
                st_fetch_index: begin
                    if (i_bus_ack) begin
                        // pc as base sees its already advanced value
                        if (is_deferred(mode_q)) begin
                            if (is_pc(sel_q)) begin
                                addr_q <= i_bus_data + pc_next;
                            end else begin
                                addr_q <= i_bus_data + gpr_q[sel_q];
                            end
                            state_q <= st_fetch_pointer;
                        end else begin
                            state_q <= st_finish;
                        end
                    end
                end
                st_fetch_pointer: begin
                    if (i_bus_ack) begin
                        state_q <= st_finish;
                    end
                end
                st_finish: begin
                    // last bus word is already in value_q here
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // specifier held for the whole operation; inputs may move once taken
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mode_q <= mode_register;
            sel_q <= 3'h0;
            byte_q <= 1'b0;
        end else if (start_ok) begin
            mode_q <= mode_d;
            sel_q <= sel_d;
            byte_q <= i_byte;
        end
    end

    // result value and kind
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            value_q <= reset_word;
            kind_q <= res_register;
        end else if (start_ok) begin
            unique case (mode_d)
                mode_register: begin
                    kind_q <= res_register;
                    value_q <= sel_val;
                end
                mode_reg_deferred, mode_autoinc: begin
                    kind_q <= res_address;
                    value_q <= sel_val;
                    if (is_immediate(mode_d, sel_d)) begin
                        kind_q <= res_immediate;
                    end
                end
                mode_autodec: begin
                    kind_q <= res_address;
                    value_q <= dec_val;
                end
                // modes with reads fill value_q at the ack
                default: begin
                    kind_q <= res_address;
                    value_q <= reset_word;
                end
            endcase
        end else if (i_bus_ack) begin
            unique case (state_q)
                st_fetch_index: begin
                    if (is_pc(sel_q)) begin
                        // relative: offset plus pc+2
                        value_q <= i_bus_data + pc_next;
                    end else begin
                        value_q <= i_bus_data + gpr_q[sel_q];
                    end
                end
                st_fetch_pointer: begin
                    value_q <= i_bus_data;
                end
                default: begin
                end
            endcase
        end
    end

    // general registers and side effects
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            for (int i = 0; i < reg_count; i++) begin
                gpr_q[i] <= reset_word;
            end
        end else begin
            // loads only while idle, so only a load in the start cycle can move a read's base
            if (i_wr_en && state_q == st_idle) begin
                gpr_q[i_wr_sel] <= i_wr_data;
            end
            if (start_ok) begin
                unique case (mode_d)
                    mode_autoinc: begin
                        // pc reads advance at the ack, others now
                        if (!is_pc(sel_d)) begin
                            gpr_q[sel_d] <= sel_val + step_w;
                        end
                    end
                    mode_autodec, mode_autodec_def: begin
                        gpr_q[sel_d] <= dec_val;
                    end
                    default: begin
                    end
                endcase
            end else if (i_bus_ack) begin
                // index fetch always via pc; pointer fetch via pc
                // only when the pc was the pointer
                if (state_q == st_fetch_index) begin
                    gpr_q[pc_reg] <= pc_next;
                end else if (state_q == st_fetch_pointer) begin
                    if (pointer_steps(mode_q, sel_q)) begin
                        gpr_q[sel_q] <= gpr_q[sel_q] + ack_step;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            done_q <= 1'b0;
        end else begin
            // trails finish by a cycle, when busy is already low
            done_q <= state_q == st_finish;
        end
    end

    // stands until the ack; the address only moves on an ack
    assign o_bus_req = state_q == st_fetch_index
        || state_q == st_fetch_pointer;
    assign o_bus_addr = addr_q;
    assign o_done = done_q;
    assign o_busy = state_q != st_idle;
    assign o_kind = kind_q;
    assign o_reg_num = sel_q;
    assign o_value = value_q;
    assign o_pc = gpr_q[pc_reg];
endmodule : operand_address_generator

// ==== bench/oag_checker.sv ====
`timescale 1ns/1ps
module oag_checker (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [5:0] i_specifier,
    input wire logic o_bus_req,
    input wire logic [15:0] o_bus_addr,
    input wire logic i_bus_ack,
    input wire logic o_done,
    input wire logic o_busy,
    input wire logic [15:0] o_value,
    input wire logic [15:0] o_pc
);
    import oag_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    wire logic go = i_start && !o_busy;
    a_done_bound: assert property (go |-> ##[2:40] o_done)
        else $error("operation did not finish");
    a_start_busy: assert property (go |=> o_busy && !o_done)
        else $error("start not taken");
    a_reg_direct: assert property (go
        && i_specifier[5:3] == mode_register
        |=> !o_bus_req ##1 (o_done && !o_bus_req))
        else $error("register mode timing wrong");
    a_reg_pc_value: assert property (go
        && i_specifier == {mode_register, pc_reg}
        |-> ##2 o_value == $past(o_pc, 2))
        else $error("pc register operand wrong");
    a_imm_fetch: assert property (go && i_specifier == spec_immediate
        |=> o_bus_req && o_bus_addr == $past(o_pc))
        else $error("immediate not fetched at pc");
    a_index_fetch: assert property (go && i_specifier[5:4] == 2'h3
        |=> o_bus_req && o_bus_addr == $past(o_pc))
        else $error("index word not fetched at pc");
    a_pc_step: assert property (o_bus_req && i_bus_ack
        && o_bus_addr == o_pc |=> o_pc == $past(o_pc) + 16'h0002)
        else $error("pc not advanced by two");
    a_addr_hold: assert property (o_bus_req && !i_bus_ack
        |=> o_bus_req && $stable(o_bus_addr))
        else $error("read request dropped early");
    a_done_pulse: assert property (o_done |=> !o_done && !o_busy)
        else $error("done not a single pulse");
    a_req_busy: assert property (o_bus_req |-> o_busy && !o_done)
        else $error("read outside an operation");
endmodule : oag_checker

// ==== bench/oag_mem_model.sv ====
`timescale 1ns/1ps
module oag_mem_model (
    input wire logic i_core_clk,
    input wire logic i_slow,
    input wire logic i_bus_req,
    input wire logic [15:0] i_bus_addr,
    output logic o_bus_ack,
    output logic [15:0] o_bus_data
);
    logic [1:0] wait_q = 2'h0;
    initial o_bus_ack = 1'b0;
    initial o_bus_data = 16'h0000;
    // fixed pattern store, so the bench needs no shared memory image
    always @(posedge i_core_clk) begin
        if (i_bus_req && !o_bus_ack && wait_q == (i_slow ? 2'h2 : 2'h0)) begin
            o_bus_ack <= 1'b1;
            o_bus_data <= i_bus_addr ^ 16'hc3a5;
            wait_q <= 2'h0;
        end else begin
            o_bus_ack <= 1'b0;
            // released bus flips each cycle, so it shows the last word only every other cycle
            o_bus_data <= ~o_bus_data;
            wait_q <= (i_bus_req && !o_bus_ack) ? wait_q + 2'h1 : 2'h0;
        end
    end
endmodule : oag_mem_model

// ==== bench/operand_address_generator_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module operand_address_generator_tb;
    import oag_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_start = 1'b0;
    logic [5:0] i_specifier = 6'h00;
    logic i_byte = 1'b0;
    logic i_wr_en = 1'b0;
    logic [2:0] i_wr_sel = 3'h0;
    logic [15:0] i_wr_data = 16'h0000;
    logic i_slow = 1'b0;
    logic o_bus_req, i_bus_ack, o_done, o_busy;
    logic [15:0] o_bus_addr, i_bus_data, o_value, o_pc;
    logic [2:0] o_reg_num;
    result_kind_t o_kind;
    int n_fail = 0;
    int n_compared = 0;
    always #5 i_core_clk = ~i_core_clk;
    operand_address_generator DUT (.i_core_clk, .i_reset, .i_start,
        .i_specifier, .i_byte, .i_wr_en, .i_wr_sel, .i_wr_data, .o_bus_req,
        .o_bus_addr, .i_bus_ack, .i_bus_data, .o_done, .o_busy, .o_kind,
        .o_reg_num, .o_value, .o_pc);
    oag_mem_model u_mem (.i_core_clk, .i_slow, .i_bus_req(o_bus_req),
        .i_bus_addr(o_bus_addr), .o_bus_ack(i_bus_ack),
        .o_bus_data(i_bus_data));
    function automatic logic [15:0] mw(input logic [15:0] a);
        return a ^ 16'hc3a5;
    endfunction : mw
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [2:0] s, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr_en <= 1'b1;
        i_wr_sel <= s;
        i_wr_data <= d;
        @(posedge i_core_clk);
        i_wr_en <= 1'b0;
    endtask : wr
    task automatic fin(input logic [15:0] ev, input result_kind_t ek,
            input logic [15:0] epc, input logic [2:0] er);
        int n;
        n = 0;
        do begin
            @(posedge i_core_clk);
            #1;
            n++;
        end while (o_done !== 1'b1 && n < 40);
        `CHK(o_done, 1'b1)
        `CHK(o_value, ev)
        `CHK(o_kind, ek)
        `CHK(o_pc, epc)
        `CHK(o_reg_num, er)
    endtask : fin
    task automatic op(input logic [5:0] sp, input logic [15:0] ev,
            input result_kind_t ek, input logic [15:0] epc,
            input logic b = 1'b0);
        @(posedge i_core_clk);
        i_start <= 1'b1;
        i_specifier <= sp;
        i_byte <= b;
        @(posedge i_core_clk);
        i_start <= 1'b0;
        fin(ev, ek, epc, sp[2:0]);
    endtask : op
    task automatic t_general();
        wr(3'h1, 16'h2000);
        wr(3'h2, 16'h3000);
        wr(3'h4, 16'h5000);
        wr(3'h5, 16'h6000);
        wr(3'h7, 16'h0100);
        op(6'h01, 16'h2000, res_register, 16'h100);
        op(6'h09, 16'h2000, res_address, 16'h100);
        op(6'h12, 16'h3000, res_address, 16'h100, 1'b1);
        op(6'h12, 16'h3001, res_address, 16'h100);
        op(6'h02, 16'h3003, res_register, 16'h100);
        op(6'h22, 16'h3002, res_address, 16'h100, 1'b1);
        op(6'h22, 16'h3000, res_address, 16'h100);
        op(6'h1c, mw(16'h5000), res_address, 16'h100, 1'b1);
        op(6'h04, 16'h5002, res_register, 16'h100);
        op(6'h2d, mw(16'h5ffe), res_address, 16'h100, 1'b1);
        op(6'h05, 16'h5ffe, res_register, 16'h100);
        op(6'h31, mw(16'h100) + 16'h2000, res_address, 16'h102);
        op(6'h39, mw(mw(16'h102) + 16'h2000), res_address, 16'h104);
        $display("t_general finished");
    endtask : t_general
    task automatic t_refuse();
        @(posedge i_core_clk);
        i_start <= 1'b1;
        i_specifier <= 6'h31;
        @(posedge i_core_clk);
        i_specifier <= 6'h01;
        i_wr_en <= 1'b1;
        i_wr_sel <= 3'h1;
        i_wr_data <= 16'hffff;
        @(posedge i_core_clk);
        i_start <= 1'b0;
        i_wr_en <= 1'b0;
        fin(mw(16'h104) + 16'h2000, res_address, 16'h106, 3'h1);
        op(6'h01, 16'h2000, res_register, 16'h106);
        $display("t_refuse finished");
    endtask : t_refuse
    task automatic t_pc(input logic s);
        i_slow <= s;
        wr(3'h7, 16'h0200);
        op(6'h17, mw(16'h200), res_immediate, 16'h202, 1'b1);
        op(6'h1f, mw(16'h202), res_address, 16'h204);
        op(6'h37, mw(16'h204)+16'h206, res_address, 16'h206);
        op(6'h3f, mw(mw(16'h206) + 16'h208), res_address, 16'h208);
        op(6'h07, 16'h208, res_register, 16'h208);
        op(6'h0f, 16'h208, res_address, 16'h208);
        op(6'h27, 16'h206, res_address, 16'h206);
        $display("t_pc finished");
    endtask : t_pc
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_reset <= 1'b0;
        @(posedge i_core_clk);
        #1;
        `CHK(o_pc, 16'h0000)
        `CHK(o_busy, 1'b0)
        t_general();
        t_refuse();
        t_pc(1'b0);
        t_pc(1'b1);
        close_out();
    end
    // whole run is under two hundred cycles
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_fail++;
        close_out();
    end
endmodule : operand_address_generator_tb
bind operand_address_generator oag_checker u_chk (.i_core_clk, .i_reset,
    .i_start, .i_specifier, .o_bus_req, .o_bus_addr, .i_bus_ack, .o_done,
    .o_busy, .o_value, .o_pc);
